// File: pkg/tap_port_pkg.sv
package tap_port_pkg;
  // tap state encodings, one-hot
  typedef enum logic [15:0] {
    ST_RESET      = 16'h0001,
    ST_IDLE       = 16'h0002,
    ST_SEL_DR     = 16'h0004,
    ST_CAP_DR     = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPD_DR     = 16'h0100,
    ST_SEL_IR     = 16'h0200,
    ST_CAP_IR     = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPD_IR     = 16'h8000
  } tap_state_t;

  localparam int IR_WIDTH = 4;
  localparam logic [3:0] IR_RESET_VALUE = 4'h1;
  localparam logic [3:0] IR_CAPTURE_VALUE = 4'h1;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_IDCODE = 4'h1;
  localparam int ID_WIDTH = 32;
  // arbitrary identification value
  localparam logic [31:0] ID_VALUE = 32'h0000_0001;
endpackage

// File: rtl/jtag_test_port_select.sv
// Operation
// - test reset low initialises the controller at once, no clock needed
// - serial output changes only on falling test clock edges
// - serial input captured on rising test clock edges
// - mode select sampled on rising edges steers the controller
// - controller select latched at test reset release chooses the controller
// - system clock samples the test clock, whose edges pace the test logic and register access
// - return clock output shares a pin with the single-wire function
`timescale 1ns/1ps
module jtag_test_port_select
  import tap_port_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  input wire logic tap_controller_select,
  input wire logic single_wire_enable,
  input wire logic single_wire_out,
  input wire logic internal_tdo,
  output logic tdo,
  output logic tdo_oe,
  output logic shared_pin_out,
  output logic shared_pin_oe,
  output logic debug_selected,
  output tap_port_pkg::tap_state_t tap_state
);
  import tap_port_pkg::*;

  // ---------------------------------------------
  // pin sampling
  // ---------------------------------------------
  logic [4:0] pins_sync;
  logic tck_s, tms_s, tdi_s, trst_s, sel_s;
  logic tck_d_reg, trst_d_reg;
  logic tck_rise, tck_fall, trst_release;

  tap_sync #(.WIDTH(5)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in({tck, tms, tdi, trst_n, tap_controller_select}),
    .sync_out(pins_sync)
  );

  assign {tck_s, tms_s, tdi_s, trst_s, sel_s} = pins_sync;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tck_d_reg <= 1'b0;
      trst_d_reg <= 1'b0;
    end
    else
    begin
      tck_d_reg <= tck_s;
      trst_d_reg <= trst_s;
    end
  end

  // edges of the test clock and of test reset release; all test logic but the select flop advances only on the clock edges
  assign tck_rise = tck_s & ~tck_d_reg;
  assign tck_fall = ~tck_s & tck_d_reg;
  assign trst_release = trst_s & ~trst_d_reg;

  // raw test reset acts immediately, even with the test clock stopped
  logic test_rst_n;
  assign test_rst_n = resetn & trst_n;

  // ---------------------------------------------
  // controller select
  // ---------------------------------------------
  logic sel_reg;

  // caught at the release edge; flop resets to debugger choice
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sel_reg <= 1'b1;
    else if (trst_release)
      sel_reg <= sel_s;
  end

  // ---------------------------------------------
  // tap state machine
  // ---------------------------------------------
  tap_state_t state_reg, state_next;

  always_comb
  begin
    case (state_reg)
      ST_RESET: state_next = tms_s ? ST_RESET : ST_IDLE;
      ST_IDLE: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_next = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_next = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_next = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_next = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: state_next = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_next = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_next = tms_s ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_next = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_next = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_next = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: state_next = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_next = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
      default: state_next = ST_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge test_rst_n)
  begin
    if (!test_rst_n)
      state_reg <= ST_RESET;
    else if (tck_rise)
      state_reg <= state_next;
  end

  // ---------------------------------------------
  // instruction and data shift paths
  // ---------------------------------------------
  logic [IR_WIDTH-1:0] ir_shift_reg, ir_reg;
  logic [ID_WIDTH-1:0] dr_shift_reg;

  always_ff @(posedge clk or negedge test_rst_n)
  begin
    if (!test_rst_n)
    begin
      ir_shift_reg <= IR_RESET_VALUE;
      ir_reg <= IR_RESET_VALUE;
    end
    else if (tck_rise)
    begin
      case (state_reg)
        ST_CAP_IR: ir_shift_reg <= IR_CAPTURE_VALUE;
        ST_SHIFT_IR: ir_shift_reg <= {tdi_s, ir_shift_reg[IR_WIDTH-1:1]};
        ST_UPD_IR: ir_reg <= ir_shift_reg;
        ST_RESET: ir_reg <= IR_RESET_VALUE;
        default: ir_reg <= ir_reg;
      endcase
    end
  end

  // bypass is one bit at the bottom of the same shifter
  always_ff @(posedge clk or negedge test_rst_n)
  begin
    if (!test_rst_n)
      dr_shift_reg <= '0;
    else if (tck_rise)
    begin
      if (state_reg == ST_CAP_DR)
        dr_shift_reg <= (ir_reg == IR_IDCODE) ? ID_VALUE : '0;
      else if (state_reg == ST_SHIFT_DR)
      begin
        if (ir_reg == IR_IDCODE)
          dr_shift_reg <= {tdi_s, dr_shift_reg[ID_WIDTH-1:1]};
        else
          dr_shift_reg <= {{(ID_WIDTH-1){1'b0}}, tdi_s};
      end
    end
  end

  // ---------------------------------------------
  // serial output and shared pin
  // ---------------------------------------------
  logic shift_bit;
  assign shift_bit = (state_reg == ST_SHIFT_IR) ? ir_shift_reg[0] : dr_shift_reg[0];

  // falling edge update gives the probe a half period of setup
  always_ff @(posedge clk or negedge test_rst_n)
  begin
    if (!test_rst_n)
    begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo <= sel_reg ? shift_bit : internal_tdo;
      tdo_oe <= (state_reg == ST_SHIFT_IR) || (state_reg == ST_SHIFT_DR);
    end
  end

  // return clock trails the sampled test clock; single-wire use takes the pin
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      shared_pin_out <= 1'b0;
      shared_pin_oe <= 1'b0;
    end
    else if (single_wire_enable)
    begin
      shared_pin_out <= single_wire_out;
      shared_pin_oe <= ~single_wire_out;
    end
    else
    begin
      shared_pin_out <= tck_s;
      shared_pin_oe <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      debug_selected <= 1'b1;
      tap_state <= ST_RESET;
    end
    else
    begin
      debug_selected <= sel_reg;
      tap_state <= state_reg;
    end
  end
endmodule // jtag_test_port_select

// File: rtl/tap_sync.sv
`timescale 1ns/1ps
module tap_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // two-flop synchroniser; first stage feeds only the second
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // tap_sync

// File: testbench/jtag_test_port_select_bench.sv
`timescale 1ns/1ps
module jtag_test_port_select_bench;
  import tap_port_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic single_wire_enable = 1'b0;
  logic single_wire_out = 1'b1;
  logic internal_tdo = 1'b0;
  logic tck, tms, tdi, trst_n, tap_controller_select, tdo, tdo_oe;
  logic shared_pin_out, shared_pin_oe, debug_selected;
  logic [31:0] q;
  tap_state_t tap_state;
  int error_cnt = 0;
  int samples_checked = 0;
  always #20 clk = ~clk;
  jtag_test_port_select i_jtag_test_port_select (.clk, .resetn, .tck, .tms, .tdi, .trst_n,
    .tap_controller_select, .single_wire_enable, .single_wire_out, .internal_tdo, .tdo,
    .tdo_oe, .shared_pin_out, .shared_pin_oe, .debug_selected, .tap_state);
  tap_probe_model i_tap_probe_model (.clk, .tdo, .tck, .tms, .tdi, .trst_n,
    .tap_controller_select);
  task automatic chk(input string s, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_idcode;
    i_tap_probe_model.rst(1'b1);
    chk("sel", debug_selected, 32'h1);
    i_tap_probe_model.bits(4, 32'h2, 32'h0, q);
    chk("state", tap_state, ST_SHIFT_DR);
    i_tap_probe_model.bits(32, 32'h8000_0000, 32'h0, q);
    chk("id", q, ID_VALUE);
    chk("oe", tdo_oe, 32'h1);
    i_tap_probe_model.bits(2, 32'h1, 32'h0, q);
    chk("state", tap_state, ST_IDLE);
    chk("oe", tdo_oe, 32'h0);
    $display("idcode done");
  endtask
  task automatic t_bypass;
    i_tap_probe_model.bits(10, 32'h183, 32'hf0, q);
    chk("ir cap", q[7:4], 32'h1);
    i_tap_probe_model.bits(13, 32'hc01, 32'h5a8, q);
    chk("bypass", q[10:3], 32'h6a);
    i_tap_probe_model.bits(5, 32'h1f, 32'h0, q);
    chk("state", tap_state, ST_RESET);
    $display("bypass done");
  endtask
  task automatic t_trst;
    i_tap_probe_model.bits(3, 32'h2, 32'h0, q);
    i_tap_probe_model.rst(1'b0);
    chk("state", tap_state, ST_RESET);
    chk("sel", debug_selected, 32'h0);
    internal_tdo = 1'b1;
    i_tap_probe_model.bits(4, 32'h2, 32'h0, q);
    i_tap_probe_model.bits(1, 32'h0, 32'h0, q);
    chk("int tdo", q[0], 32'h1);
    internal_tdo = 1'b0;
    i_tap_probe_model.rst(1'b1);
    chk("sel", debug_selected, 32'h1);
    $display("trst done");
  endtask
  task automatic t_shared;
    @(negedge clk);
    single_wire_enable = 1'b1;
    single_wire_out = 1'b0;
    repeat (4) @(negedge clk);
    chk("sw oe", shared_pin_oe, 32'h1);
    single_wire_out = 1'b1;
    repeat (4) @(negedge clk);
    chk("sw oe", shared_pin_oe, 32'h0);
    chk("sw out", shared_pin_out, 32'h1);
    single_wire_enable = 1'b0;
    repeat (4) @(negedge clk);
    chk("ret clk oe", shared_pin_oe, 32'h1);
    chk("ret clk out", shared_pin_out, 32'h0);
    $display("shared pin done");
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    t_idcode();
    t_bypass();
    t_trst();
    t_shared();
    end_sim();
  end
endmodule // jtag_test_port_select_bench

// File: testbench/jtag_test_port_select_properties.sv
`timescale 1ns/1ps
module tap_port_checker
  import tap_port_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tap_controller_select,
  input wire logic single_wire_enable,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic shared_pin_out,
  input wire logic shared_pin_oe,
  input wire logic debug_selected,
  input tap_state_t tap_state
);
  // ----
  // port checks
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  tdo_hold_a: assert property ((trst_n && tck) [*4] |-> $stable(tdo))
    else $error("tdo moved in tck high");
  trst_clear_a: assert property (!trst_n |-> !tdo && !tdo_oe)
    else $error("tdo not cleared");
  trst_state_a: assert property (!trst_n ##1 !trst_n |=> tap_state == ST_RESET)
    else $error("state not reset");
  state_onehot_a: assert property ($onehot(tap_state))
    else $error("state not one-hot");
  oe_shift_a: assert property ($rose(tdo_oe) |-> tap_state inside {ST_SHIFT_DR, ST_SHIFT_IR})
    else $error("tdo enabled off shift");
  sel_latch_a: assert property ($rose(trst_n) |-> ##[1:6] debug_selected == tap_controller_select)
    else $error("select not latched");
  sel_hold_a: assert property (trst_n [*8] |-> $stable(debug_selected))
    else $error("select moved");
  ret_clk_oe_a: assert property (!single_wire_enable [*3] |-> shared_pin_oe)
    else $error("return clock not driven");
  ret_clk_follow_a: assert property ($rose(tck) && !single_wire_enable |-> ##[2:5] shared_pin_out)
    else $error("return clock lost");
endmodule // tap_port_checker
bind jtag_test_port_select tap_port_checker i_tap_port_checker (.clk, .resetn, .tck, .trst_n,
  .tap_controller_select, .single_wire_enable, .tdo, .tdo_oe, .shared_pin_out, .shared_pin_oe,
  .debug_selected, .tap_state);

// File: testbench/tap_probe_model.sv
`timescale 1ns/1ps
module tap_probe_model (
  input wire logic clk,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  output logic tap_controller_select
);
  initial {tck, tms, tdi, trst_n, tap_controller_select} = 5'h09;
  // ----
  // probe actions
  // ----
  task automatic rst(input logic sel);
    @(negedge clk);
    trst_n = 1'b0;
    repeat (3) @(negedge clk);
    tap_controller_select = sel; // low only for factory use
    @(negedge clk);
    trst_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  task automatic bits(input int n, input logic [31:0] m, d, output logic [31:0] q);
    q = 32'h0;
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk);
      tms = m[i];
      tdi = d[i]; // set up three clocks before the rising edge
      repeat (3) @(negedge clk);
      q[i] = tdo;
      tck = 1'b1;
      repeat (4) @(negedge clk);
      tck = 1'b0; // rests low between frames
    end
  endtask
endmodule // tap_probe_model
